// ### core/ccu_unit.sv
// capture/compare unit with a classic wishbone register slave
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`default_nettype none
module ccu_unit #(
   parameter int UNIT_ID = 0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // time bases and timer requests
   input wire ccu_pkg::ccu_time_base_t time_base,
   output ccu_pkg::ccu_trigger_t trigger,
   // unit pin slots
   input wire logic [2:0] unit_pin_in,
   output logic [2:0] unit_pin_out,
   output logic [2:0] unit_pin_oe,
   // status levels
   output logic unit_event_flag,
   output logic timer_three_in_use
);
   logic [7:0] control_reg;
   logic [7:0] data_low_reg;
   logic [7:0] data_high_reg;
   logic [7:0] config_reg;
   logic flag_reg;
   logic latch_reg;
   logic [3:0] presc_reg;
   logic [2:0] pin_meta_reg;
   logic [2:0] pin_sync_reg;
   logic level_prev_reg;
   logic match_prev_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   ccu_pkg::ccu_trigger_t trig_reg;
   logic [2:0] pin_out_reg;
   logic [2:0] pin_oe_reg;
   logic flag_out_reg;
   logic t3_out_reg;

   // true when this unit sits on timer three under the given layout
   function automatic logic uses_timer_three(input logic [1:0] sel);
      logic r;
      r = 1'b0;
      case (sel)
         ccu_pkg::CCU_SEL_ALL_T1: r = 1'b0;
         ccu_pkg::CCU_SEL_U1_T1: r = (UNIT_ID != ccu_pkg::CCU_UNIT_E1);
         ccu_pkg::CCU_SEL_U12_T1: r = (UNIT_ID > ccu_pkg::CCU_UNIT_E2);
         ccu_pkg::CCU_SEL_ALL_T3: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // pin slot in use; only enhanced unit two can be rerouted
   function automatic logic [1:0] pin_slot(input logic route, input logic mcu);
      logic [1:0] s;
      s = 2'(ccu_pkg::CCU_PIN_DEFAULT);
      if ((UNIT_ID == ccu_pkg::CCU_UNIT_E2) && !route) begin
         s = mcu ? 2'(ccu_pkg::CCU_PIN_ALT_MCU) : 2'(ccu_pkg::CCU_PIN_ALT_OTHER);
      end
      return s;
   endfunction

   logic [3:0] mode;
   logic mode_off;
   logic mode_capture;
   logic mode_compare;
   logic [1:0] timer_sel;
   logic use_t3;
   logic [15:0] base_count;
   logic [15:0] data_word;
   logic [1:0] slot;
   logic pin_driven;
   logic edge_level;
   logic rise;
   logic fall;
   logic match;
   logic match_event;
   logic capture_event;
   logic compare_event;
   logic bus_req;
   logic bus_wr;
   logic [3:0] wr_mode;
   logic mode_write;
   logic presc_mode;

   assign mode = control_reg[ccu_pkg::CCU_MODE_LSB +: 4];
   assign mode_off = (mode == ccu_pkg::CCU_M_OFF);
   assign mode_capture = (mode[3:2] == ccu_pkg::CCU_M_CAP_FALL[3:2]);
   // 11xx is pwm, neither capture nor compare here
   // 10xx compare group shares its top bits with 1000
   assign mode_compare = (mode == ccu_pkg::CCU_M_CMP_TOGGLE) ||
      (mode[3:2] == ccu_pkg::CCU_M_CMP_SET[3:2]);
   // only the two prescaled codes advance the edge counter
   assign presc_mode = (mode == ccu_pkg::CCU_M_CAP_RISE4) ||
      (mode == ccu_pkg::CCU_M_CAP_RISE16);
   assign timer_sel = {config_reg[ccu_pkg::CCU_CF_SEL_HIGH], config_reg[ccu_pkg::CCU_CF_SEL_LOW]};
   // select bits pick the time base
   assign use_t3 = uses_timer_three(timer_sel);
   // capture/compare only ever sees timer one or three
   assign base_count = use_t3 ? time_base.timer_three_count : time_base.timer_one_count;
   assign data_word = {data_high_reg, data_low_reg};
   // route bit and memory mode pick the pin
   assign slot = pin_slot(config_reg[ccu_pkg::CCU_CF_ROUTE], config_reg[ccu_pkg::CCU_CF_MCU_MODE]);
   assign pin_driven = config_reg[ccu_pkg::CCU_CF_PIN_DRIVE];

   // limitation: flipping drive or route can itself look like a pin edge
   // a driven pin shows the port latch to the edge detector
   assign edge_level = pin_driven ? config_reg[ccu_pkg::CCU_CF_PORT_LATCH] : pin_sync_reg[slot];
   assign rise = edge_level && !level_prev_reg;
   assign fall = !edge_level && level_prev_reg;

   // match held over many cycles while the timer stalls; act on its first cycle only
   assign match = mode_compare && (base_count == data_word);
   assign match_event = match && !match_prev_reg;
   assign compare_event = match_event;

   always_comb begin
      capture_event = 1'b0;
      case (mode)
         ccu_pkg::CCU_M_CAP_FALL: capture_event = fall;
         ccu_pkg::CCU_M_CAP_RISE: capture_event = rise;
         ccu_pkg::CCU_M_CAP_RISE4: begin
            capture_event = rise && ((presc_reg & ccu_pkg::CCU_PRESC_4_MASK) ==
               ccu_pkg::CCU_PRESC_4_LAST);
         end
         ccu_pkg::CCU_M_CAP_RISE16: begin
            capture_event = rise && (presc_reg == ccu_pkg::CCU_PRESC_16_LAST);
         end
         default: capture_event = 1'b0;
      endcase
   end

   // ack in the term keeps a strobe held past ack from being taken twice
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
   // mode field of a control write that changes the mode
   assign wr_mode = wb_dat_i[ccu_pkg::CCU_MODE_LSB +: 4];
   assign mode_write = bus_wr && (wb_adr_i == ccu_pkg::CCU_OFF_CONTROL) && (wr_mode != mode);

   // pin synchroniser; first stage read only by the second
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_meta_reg <= 3'h0;
         pin_sync_reg <= 3'h0;
      end else begin
         pin_meta_reg <= unit_pin_in;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // edge and match history
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         level_prev_reg <= 1'b0;
         match_prev_reg <= 1'b0;
      end else if (mode_off) begin
         level_prev_reg <= edge_level;
         match_prev_reg <= 1'b0;
      end else begin
         level_prev_reg <= edge_level;
         match_prev_reg <= match;
      end
   end

   // cleared whenever off or outside capture
   // no clear on a direct switch between prescale codes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         presc_reg <= 4'h0;
      end else if (mode_off || !mode_capture) begin
         presc_reg <= 4'h0;
      end else if (rise && presc_mode) begin
         presc_reg <= presc_reg + 4'h1;
      end
   end

   // duty low bits stored in all modes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         control_reg <= ccu_pkg::CCU_CONTROL_RESET;
      end else if (bus_wr && wb_adr_i == ccu_pkg::CCU_OFF_CONTROL) begin
         control_reg <= wb_dat_i[7:0] & ccu_pkg::CCU_CONTROL_WMASK;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         config_reg <= ccu_pkg::CCU_CONFIG_RESET;
      end else if (bus_wr && wb_adr_i == ccu_pkg::CCU_OFF_CONFIG) begin
         // route and drive switch at once; turn the unit off first
         config_reg <= wb_dat_i[7:0] & ccu_pkg::CCU_CONFIG_WMASK;
      end
   end

   // later capture simply overwrites, hardware beats a same-cycle write
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_low_reg <= 8'h00;
         data_high_reg <= 8'h00;
      end else if (capture_event) begin
         data_low_reg <= base_count[7:0];
         data_high_reg <= base_count[15:8];
      end else if (bus_wr && wb_adr_i == ccu_pkg::CCU_OFF_DATA_LOW) begin
         data_low_reg <= wb_dat_i[7:0];
      end else if (bus_wr && wb_adr_i == ccu_pkg::CCU_OFF_DATA_HIGH) begin
         data_high_reg <= wb_dat_i[7:0];
      end
   end

   // set by hardware, cleared only by a one written to status; set wins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_reg <= 1'b0;
      end else if (capture_event || compare_event) begin
         flag_reg <= 1'b1;
      end else if (bus_wr && wb_adr_i == ccu_pkg::CCU_OFF_STATUS &&
                   wb_dat_i[ccu_pkg::CCU_ST_FLAG]) begin
         flag_reg <= 1'b0;
      end
   end

   // compare output latch
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         latch_reg <= 1'b0;
      end else if (mode_write) begin
         // entry beats the off clear, else 1001 written from off would start low
         // entering set mode starts low
         latch_reg <= (wr_mode == ccu_pkg::CCU_M_CMP_CLEAR);
      end else if (mode_off) begin
         // latch back to its default low
         latch_reg <= 1'b0;
      end else if (compare_event) begin
         case (mode)
            ccu_pkg::CCU_M_CMP_TOGGLE: latch_reg <= !latch_reg;
            ccu_pkg::CCU_M_CMP_SET: latch_reg <= 1'b1;
            ccu_pkg::CCU_M_CMP_CLEAR: latch_reg <= 1'b0;
            default: latch_reg <= latch_reg;
         endcase
      end
   end

   // registered so each timer sees a clean single-cycle request
   // one-cycle trigger in trigger mode only
   // reset only the timer that is this unit's base
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         trig_reg <= '0;
      end else begin
         trig_reg.special_trigger <= compare_event && (mode == ccu_pkg::CCU_M_CMP_TRIG);
         trig_reg.reset_timer_one <= compare_event && (mode == ccu_pkg::CCU_M_CMP_TRIG) &&
            !use_t3;
         trig_reg.reset_timer_three <= compare_event && (mode == ccu_pkg::CCU_M_CMP_TRIG) &&
            use_t3;
      end
   end

   // pin drive: compare latch owns the pin in modes 0010, 1000, 1001
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_out_reg <= 3'h0;
         pin_oe_reg <= 3'h0;
      end else begin
         pin_out_reg <= 3'h0;
         pin_oe_reg <= 3'h0;
         pin_oe_reg[slot] <= pin_driven;
         if (mode == ccu_pkg::CCU_M_CMP_TOGGLE || mode == ccu_pkg::CCU_M_CMP_SET ||
             mode == ccu_pkg::CCU_M_CMP_CLEAR) begin
            pin_out_reg[slot] <= latch_reg;
         end else begin
            pin_out_reg[slot] <= config_reg[ccu_pkg::CCU_CF_PORT_LATCH];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_out_reg <= 1'b0;
         t3_out_reg <= 1'b0;
      end else begin
         // software sees the flag one cycle after it is set or cleared
         flag_out_reg <= flag_reg;
         t3_out_reg <= use_t3;
      end
   end

   // wishbone: answer one cycle after the request, unmapped reads zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= bus_req;
         rdata_reg <= 32'h0000_0000;
         if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
               // readable control with zero top bits
               ccu_pkg::CCU_OFF_CONTROL: rdata_reg[7:0] <= control_reg;
               ccu_pkg::CCU_OFF_DATA_LOW: rdata_reg[7:0] <= data_low_reg;
               ccu_pkg::CCU_OFF_DATA_HIGH: rdata_reg[7:0] <= data_high_reg;
               ccu_pkg::CCU_OFF_STATUS: begin
                  rdata_reg[ccu_pkg::CCU_ST_FLAG] <= flag_reg;
                  rdata_reg[ccu_pkg::CCU_ST_LATCH] <= latch_reg;
                  rdata_reg[ccu_pkg::CCU_ST_TIMER3] <= use_t3;
                  rdata_reg[ccu_pkg::CCU_ST_PRESC_LSB +: ccu_pkg::CCU_PRESC_W] <= presc_reg;
               end
               ccu_pkg::CCU_OFF_CONFIG: rdata_reg[7:0] <= config_reg;
               default: rdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;
   assign trigger = trig_reg;
   assign unit_pin_out = pin_out_reg;
   assign unit_pin_oe = pin_oe_reg;
   assign unit_event_flag = flag_out_reg;
   assign timer_three_in_use = t3_out_reg;
endmodule
`default_nettype wire

// ### core/ccu_pkg.sv
// constants, field layouts and carrier types of the capture/compare unit
`default_nettype none
package ccu_pkg;
   // word-aligned byte offsets on the register bus
   localparam logic [7:0] CCU_OFF_CONTROL = 8'h00;
   localparam logic [7:0] CCU_OFF_DATA_LOW = 8'h04;
   localparam logic [7:0] CCU_OFF_DATA_HIGH = 8'h08;
   localparam logic [7:0] CCU_OFF_STATUS = 8'h0C;
   localparam logic [7:0] CCU_OFF_CONFIG = 8'h10;

   // unit_control fields
   localparam int CCU_MODE_LSB = 0;
   localparam int CCU_DUTY_LSB = 4;
   localparam logic [7:0] CCU_CONTROL_WMASK = 8'h3F;
   localparam logic [7:0] CCU_CONTROL_RESET = 8'h00;

   // unit_status fields
   localparam int CCU_ST_FLAG = 0;
   localparam int CCU_ST_LATCH = 1;
   localparam int CCU_ST_TIMER3 = 2;
   localparam int CCU_ST_PRESC_LSB = 4;

   // unit_config fields
   localparam int CCU_CF_PORT_LATCH = 0;
   localparam int CCU_CF_PIN_DRIVE = 1;
   localparam int CCU_CF_SEL_LOW = 2;
   localparam int CCU_CF_SEL_HIGH = 3;
   localparam int CCU_CF_ROUTE = 4;
   localparam int CCU_CF_MCU_MODE = 5;
   localparam logic [7:0] CCU_CONFIG_WMASK = 8'h3F;
   localparam logic [7:0] CCU_CONFIG_RESET = 8'h10;

   // mode codes
   localparam logic [3:0] CCU_M_OFF = 4'h0;
   localparam logic [3:0] CCU_M_CMP_TOGGLE = 4'h2;
   localparam logic [3:0] CCU_M_CAP_FALL = 4'h4;
   localparam logic [3:0] CCU_M_CAP_RISE = 4'h5;
   localparam logic [3:0] CCU_M_CAP_RISE4 = 4'h6;
   localparam logic [3:0] CCU_M_CAP_RISE16 = 4'h7;
   localparam logic [3:0] CCU_M_CMP_SET = 4'h8;
   localparam logic [3:0] CCU_M_CMP_CLEAR = 4'h9;
   localparam logic [3:0] CCU_M_CMP_SOFT = 4'hA;
   localparam logic [3:0] CCU_M_CMP_TRIG = 4'hB;

   // prescaler terminal counts
   localparam int CCU_PRESC_W = 4;
   localparam logic [3:0] CCU_PRESC_4_LAST = 4'h3;
   localparam logic [3:0] CCU_PRESC_16_LAST = 4'hF;
   localparam logic [3:0] CCU_PRESC_4_MASK = 4'h3;

   // timer select layouts
   localparam logic [1:0] CCU_SEL_ALL_T1 = 2'h0;
   localparam logic [1:0] CCU_SEL_U1_T1 = 2'h1;
   localparam logic [1:0] CCU_SEL_U12_T1 = 2'h2;
   localparam logic [1:0] CCU_SEL_ALL_T3 = 2'h3;

   // unit numbering and pin slots
   localparam int CCU_UNIT_E1 = 0;
   localparam int CCU_UNIT_E2 = 1;
   localparam int CCU_PIN_DEFAULT = 0;
   localparam int CCU_PIN_ALT_MCU = 1;
   localparam int CCU_PIN_ALT_OTHER = 2;
   localparam int CCU_PINS = 3;

   // two candidate time bases, same clock domain
   typedef struct packed {
      logic [15:0] timer_one_count;
      logic [15:0] timer_three_count;
   } ccu_time_base_t;

   // one-cycle requests to the timers
   typedef struct packed {
      logic special_trigger;
      logic reset_timer_one;
      logic reset_timer_three;
   } ccu_trigger_t;
endpackage
`default_nettype wire

// ### verification/ccu_unit_asserts.sv
// port assertions of the capture/compare unit and their bind
`default_nettype none
module ccu_unit_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // unit outputs
   input wire ccu_pkg::ccu_trigger_t trigger,
   input wire logic [2:0] unit_pin_oe,
   input wire logic unit_event_flag
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
   wire logic clr = take && wb_adr_i == ccu_pkg::CCU_OFF_STATUS && wb_dat_i[0];
   logic [3:0] mode_q;
   // mode as software last wrote it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= 4'h0;
      end else if (take && wb_adr_i == ccu_pkg::CCU_OFF_CONTROL) begin
         mode_q <= wb_dat_i[3:0];
      end
   end
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in the next cycle");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data not zero outside ack");
   AST_DAT_TOP: assert property (wb_ack_o && wb_adr_i == ccu_pkg::CCU_OFF_CONTROL
      |-> wb_dat_o[31:6] == '0) else $error("control top bits not zero");
   AST_TRIG_ONE: assert property (trigger.special_trigger |=> !trigger.special_trigger)
      else $error("trigger longer than one cycle");
   AST_TRIG_BASE: assert property (trigger.special_trigger
      |-> trigger.reset_timer_one ^ trigger.reset_timer_three) else $error("trigger base");
   AST_TRIG_ONLY: assert property (trigger.reset_timer_one || trigger.reset_timer_three
      |-> trigger.special_trigger) else $error("timer reset without trigger");
   AST_TRIG_MODE: assert property (trigger.special_trigger
      |-> mode_q == ccu_pkg::CCU_M_CMP_TRIG) else $error("trigger outside its mode");
   AST_FLAG_KEEP: assert property ($fell(unit_event_flag) |-> $past(clr, 2))
      else $error("event flag cleared by hardware");
   AST_PIN_SLOT: assert property ($onehot0(unit_pin_oe))
      else $error("more than one pin slot driven");
endmodule
bind ccu_unit ccu_unit_asserts i_asserts (
   .clk(clk),
   .rst_b(rst_b),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .trigger(trigger),
   .unit_pin_oe(unit_pin_oe),
   .unit_event_flag(unit_event_flag)
);
`default_nettype wire

// ### verification/ccu_pin_src.sv
// signal source standing on the far side of the unit pin
`default_nettype none
module ccu_pin_src (
   // clock
   input wire logic clk,
   // level offered on the default slot
   input wire logic level,
   // unit side
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   output logic [2:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic noise = 1'b0;
   // idle slots 1 and 2 wobble so a wrong route cannot pass unseen
   always @(posedge clk) begin
      noise <= !noise;
   end
   // a driven slot reads back its own driver
   always_comb begin
      pin_in[0] = pin_oe[0] ? pin_out[0] : level;
      pin_in[2:1] = (pin_out[2:1] & pin_oe[2:1]) | ({2{noise}} & ~pin_oe[2:1]);
   end
endmodule
`default_nettype wire

// ### verification/ccu_unit_tb.sv
// self-checking bench of the capture/compare unit
`default_nettype none
module ccu_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] a_ctl = ccu_pkg::CCU_OFF_CONTROL;
   localparam logic [7:0] a_lo = ccu_pkg::CCU_OFF_DATA_LOW;
   localparam logic [7:0] a_hi = ccu_pkg::CCU_OFF_DATA_HIGH;
   localparam logic [7:0] a_st = ccu_pkg::CCU_OFF_STATUS;
   localparam logic [7:0] a_cf = ccu_pkg::CCU_OFF_CONFIG;
   logic clk, rst_b, cyc, stb, we, ack, flag, t3use, level, run;
   logic [7:0] adr, rd_q;
   logic [3:0] sel, bsel;
   logic [31:0] wdat, rdat;
   logic [15:0] t1, t3;
   logic [2:0] pin_in, pin_out, pin_oe;
   ccu_pkg::ccu_trigger_t trig;
   int fail_count, cmp_count;
   ccu_unit #(.UNIT_ID(1)) i_dut (
      .clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .time_base({t1, t3}), .trigger(trig), .unit_pin_in(pin_in), .unit_pin_out(pin_out),
      .unit_pin_oe(pin_oe), .unit_event_flag(flag), .timer_three_in_use(t3use)
   );
   ccu_pin_src i_src (
      .clk(clk), .level(level), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in)
   );
   // timer counts on the system clock
   always @(posedge clk) begin
      if (run) begin
         t1 <= trig.reset_timer_one ? 16'h0000 : t1 + 16'h0001;
      end
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      {cyc, stb, we, adr, sel} <= {2'b11, w, a, bsel};
      wdat <= {24'h00_0000, d};
      // ack and read data are taken at the rising edge that samples ack high
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd_q = rdat[7:0];
      if (ack !== 1'b1) begin
         fail_count++;
         end_of_test();
      end
      {cyc, stb} <= 2'b00;
   endtask
   task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      check(what, rd_q, exp);
   endtask
   task automatic pin(input logic v);
      @(posedge clk);
      level <= v;
      repeat (6) @(posedge clk);
   endtask
   task automatic rises(input int n);
      repeat (n) begin
         pin(1'b1);
         pin(1'b0);
      end
   endtask
   task automatic mode(input logic [7:0] m);
      bus(1'b1, a_ctl, m);
      // drop the spurious event of a mode change
      bus(1'b1, a_st, 8'h01);
      repeat (2) @(posedge clk);
   endtask
   task automatic wait_flag();
      int n;
      n = 0;
      while (flag !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      check("event flag", flag, 1'b1);
      if (flag !== 1'b1) begin
         end_of_test();
      end
      @(posedge clk);
   endtask
   task automatic t_regs();
      rdc("control", a_ctl, 8'h00);
      rdc("config", a_cf, 8'h10);
      bus(1'b1, a_ctl, 8'hFF);
      rdc("control top", a_ctl, 8'h3F);
      bus(1'b1, a_lo, 8'hA5);
      bus(1'b1, a_hi, 8'h5A);
      bsel = 4'hE;
      bus(1'b1, a_lo, 8'h11);
      bsel = 4'hF;
      rdc("data low", a_lo, 8'hA5);
      rdc("data high", a_hi, 8'h5A);
      rdc("unmapped", 8'h14, 8'h00);
   endtask
   task automatic t_route();
      logic [7:0] cf [3] = '{8'h12, 8'h22, 8'h02};
      logic [2:0] oe [3] = '{3'h1, 3'h2, 3'h4};
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, a_cf, cf[i]);
         repeat (2) @(posedge clk);
         check("pin enable", pin_oe, oe[i]);
      end
      for (int s = 0; s < 4; s++) begin
         bus(1'b1, a_cf, 8'h10 | 8'(s << 2));
         repeat (2) @(posedge clk);
         check("timer three use", t3use, s % 2);
      end
   endtask
   task automatic t_capture();
      t1 <= 16'h1234;
      t3 <= 16'hBEEF;
      mode(8'h05);
      pin(1'b1);
      check("capture flag", flag, 1'b1);
      rdc("base low", a_lo, 8'hEF);
      rdc("base high", a_hi, 8'hBE);
      bus(1'b1, a_cf, 8'h10);
      pin(1'b0);
      pin(1'b1);
      rdc("overwrite low", a_lo, 8'h34);
      rdc("overwrite high", a_hi, 8'h12);
      t1 <= 16'hABCD;
      pin(1'b0);
      rdc("rise only", a_hi, 8'h12);
      check("flag kept", flag, 1'b1);
      mode(8'h04);
      pin(1'b1);
      check("fall only", flag, 1'b0);
      pin(1'b0);
      rdc("fall capture", a_hi, 8'hAB);
   endtask
   task automatic t_presc();
      logic [7:0] m [2] = '{8'h06, 8'h07};
      int cnt [2] = '{4, 16};
      for (int i = 0; i < 2; i++) begin
         // unit off before a new prescale
         mode(8'h00);
         mode(m[i]);
         rises(cnt[i] - 1);
         check("early prescale", flag, 1'b0);
         rises(1);
         check("prescale capture", flag, 1'b1);
      end
      mode(8'h06);
      rises(2);
      mode(8'h07);
      bus(1'b0, a_st, 8'h00);
      check("prescale kept", rd_q[7:4], 4'h2);
      mode(8'h00);
      bus(1'b0, a_st, 8'h00);
      check("prescale cleared", rd_q[7:4], 4'h0);
   endtask
   task automatic t_cmp();
      logic [3:0] m [5] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB};
      logic [1:0] pv [5] = '{2'b01, 2'b10, 2'b01, 2'b00, 2'b00};
      bus(1'b1, a_cf, 8'h12);
      bus(1'b1, a_lo, 8'h40);
      bus(1'b1, a_hi, 8'h00);
      for (int i = 0; i < 5; i++) begin
         t1 <= 16'h0000;
         mode({4'h0, m[i]});
         if (i < 4) begin
            check("pin at entry", pin_out[0], pv[i][1]);
         end
         run <= 1'b1;
         wait_flag();
         repeat (4) @(posedge clk);
         run <= 1'b0;
         if (i < 4) begin
            check("pin after match", pin_out[0], pv[i][0]);
         end
         // timer stopped for an edge before the next reload
         @(posedge clk);
      end
      check("timer restarted", t1 < 16'h0010, 1'b1);
      mode(8'h00);
      mode(8'h09);
      check("clear mode from off", pin_out[0], 1'b1);
   endtask
   task automatic t_latch();
      bus(1'b1, a_cf, 8'h12);
      mode(8'h05);
      bus(1'b1, a_cf, 8'h13);
      repeat (6) @(posedge clk);
      check("port write capture", flag, 1'b1);
   endtask
   initial begin
      {rst_b, cyc, stb, we, level, run} = '0;
      {adr, sel, bsel, wdat} = {8'h00, 4'hF, 4'hF, 32'h0000_0000};
      {t1, t3} = 32'h0000_0000;
      fail_count = 0;
      cmp_count = 0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_route();
      t_capture();
      t_presc();
      t_cmp();
      t_latch();
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rdc("config after reset", a_cf, 8'h10);
      end_of_test();
   end
endmodule
`default_nettype wire
